// file: hdl/uts_pkg.sv
// Package: register map, field layout and record type of the status FIFO
package uts_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] STAT_OFS  = 8'h00;  // usb_last_transfer_status
  localparam logic [7:0] ADDR_OFS  = 8'h04;  // usb_function_address
  localparam logic [7:0] IFLAG_OFS = 8'h08;  // usb_interrupt_flags, W1C
  localparam logic [7:0] IMASK_OFS = 8'h0c;  // Interrupt mask
  localparam logic [7:0] LEVEL_OFS = 8'h10;  // FIFO fill level, read only

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int          EP_MSB      = 7;
  localparam int          EP_LSB      = 4;
  localparam int          DIR_BIT     = 3;
  localparam int          BANK_BIT    = 2;
  localparam int          LSPD_BIT    = 7;
  localparam int          TRN_BIT     = 3;
  localparam int          OVF_BIT     = 0;
  localparam logic [7:0]  ADDR_RST    = 8'h00;
  localparam logic [7:0]  IFLAG_RST   = 8'h00;
  localparam logic [7:0]  IMASK_RST   = 8'h00;
  localparam int          FIFO_DEPTH  = 4;

  // One status record per completed transaction
  typedef struct packed {
    logic [3:0] last_endpoint_number;
    logic       tx_dir;
    logic       pingpong_bank_indicator;
  } uts_rec_t;

endpackage : uts_pkg

// file: hdl/uts_fifo.sv
// Small synchronous FIFO holding transaction status records
`timescale 1ns/100ps
`default_nettype none
module uts_fifo #(
  parameter int DEPTH = uts_pkg::FIFO_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_push,
  input  var  uts_pkg::uts_rec_t i_data,
  input  wire logic             i_pop,
  output var  uts_pkg::uts_rec_t o_head,
  output logic                  o_empty,
  output logic                  o_full,
  output logic [AW:0]           o_count
);

  uts_pkg::uts_rec_t mem_q [DEPTH];
  logic [AW-1:0]     wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]       cnt_q, cnt_d;
  logic              do_push, do_pop;

  // ---------------------------------------------------------------------------
  // Pointer and count update
  // ---------------------------------------------------------------------------
  always_comb begin
    do_pop  = i_pop && (cnt_q != '0);
    do_push = i_push && ((cnt_q != (AW+1)'(DEPTH)) || do_pop);
    wp_d    = do_push ? wp_q + 1'b1 : wp_q;
    rp_d    = do_pop ? rp_q + 1'b1 : rp_q;
    cnt_d   = cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem_q[wp_q] <= i_data;
    end
  end

  assign o_head  = mem_q[rp_q];
  assign o_empty = (cnt_q == '0);
  assign o_full  = (cnt_q == (AW+1)'(DEPTH));
  assign o_count = cnt_q;

endmodule // uts_fifo
`default_nettype wire

// file: hdl/uts_status_top.sv
// Transaction status FIFO, address register and APB slave
// Notes on behaviour
// [RULE1] Status bits 7:4 give last endpoint
// [RULE2] Status bit 3: one transmit, zero receive
// [RULE3] Status bit 2: one odd, zero even bank
// [RULE4] Status register shows head of four-entry FIFO
// [RULE5] Status valid only while complete flag set
// [RULE6] Clearing complete flag pops the FIFO head
// [RULE7] Status bits 31:8, 1:0 read zero
// [RULE8] Address bit 7 selects low-speed next token
// [RULE9] Address bits 6:0 hold device address
// [RULE10] Each transaction pushes; flag while entries remain; code drops one arriving when full and not popped, setting overflow
`timescale 1ns/100ps
`default_nettype none
module uts_status_top #(
  parameter int DEPTH = uts_pkg::FIFO_DEPTH
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  output logic [31:0]            o_prdata,
  // Transaction completion from the USB engine
  input  wire logic              i_trn_done,
  input  var  uts_pkg::uts_rec_t i_trn_rec,
  // Engine controls and interrupt
  output logic                   o_low_speed_token_select,
  output logic [6:0]             o_function_address_field,
  output logic                   o_irq
);

  localparam int AW = $clog2(DEPTH);

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic hit;

  function automatic logic is_reg(input logic [7:0] a);
    is_reg = (a == uts_pkg::STAT_OFS) || (a == uts_pkg::ADDR_OFS) ||
             (a == uts_pkg::IFLAG_OFS) || (a == uts_pkg::IMASK_OFS) ||
             (a == uts_pkg::LEVEL_OFS);
  endfunction

  // Zero wait states; unmapped addresses answer with an error
  always_comb begin
    hit   = is_reg(i_paddr);
    wr_en = i_psel && i_penable && i_pwrite && hit;
    rd_en = i_psel && i_penable && !i_pwrite;
  end
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;

  // ---------------------------------------------------------------------------
  // Status FIFO
  // ---------------------------------------------------------------------------
  uts_pkg::uts_rec_t head;
  logic              fifo_empty;
  logic              fifo_full;
  logic [AW:0]       fifo_cnt;
  logic              pop;
  logic              ovf_ev;

  // W1C of the complete flag advances the FIFO
  assign pop = wr_en && (i_paddr == uts_pkg::IFLAG_OFS) &&
               i_pwdata[uts_pkg::TRN_BIT] && !fifo_empty; // see [RULE6]
  // A record lost when full and not popped at the same edge
  assign ovf_ev = i_trn_done && fifo_full && !pop;

  uts_fifo #(
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_push  (i_trn_done),       // see [RULE10]
    .i_data  (i_trn_rec),
    .i_pop   (pop),
    .o_head  (head),             // see [RULE4]
    .o_empty (fifo_empty),
    .o_full  (fifo_full),
    .o_count (fifo_cnt)
  );

  // ---------------------------------------------------------------------------
  // Address, flags and mask registers
  // ---------------------------------------------------------------------------
  logic [7:0] addr_q, addr_d;
  logic [7:0] mask_q, mask_d;
  logic       ovf_q, ovf_d;
  logic [7:0] flags;

  // Complete flag is the FIFO non-empty state, so a push in the pop
  // cycle keeps it set
  always_comb begin
    addr_d = addr_q;
    mask_d = mask_q;
    ovf_d  = ovf_q;
    if (wr_en && i_paddr == uts_pkg::ADDR_OFS) begin
      addr_d = i_pwdata[7:0];    // see [RULE8] see [RULE9]
    end
    if (wr_en && i_paddr == uts_pkg::IMASK_OFS) begin
      mask_d = i_pwdata[7:0];
    end
    if (wr_en && i_paddr == uts_pkg::IFLAG_OFS &&
        i_pwdata[uts_pkg::OVF_BIT]) begin
      ovf_d = 1'b0;
    end
    if (ovf_ev) begin
      ovf_d = 1'b1;              // Set wins over clear
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_q <= uts_pkg::ADDR_RST;
      mask_q <= uts_pkg::IMASK_RST;
      ovf_q  <= 1'b0;
    end else begin
      addr_q <= addr_d;
      mask_q <= mask_d;
      ovf_q  <= ovf_d;
    end
  end

  // Flag register image
  always_comb begin
    flags                   = uts_pkg::IFLAG_RST;
    flags[uts_pkg::TRN_BIT] = !fifo_empty;  // see [RULE10]
    flags[uts_pkg::OVF_BIT] = ovf_q;
  end

  assign o_low_speed_token_select = addr_q[uts_pkg::LSPD_BIT];
  assign o_function_address_field = addr_q[6:0];
  assign o_irq                    = |(flags & mask_q);

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] stat_img;

  // Status image; invalid (shown zero) while the FIFO is empty
  always_comb begin
    stat_img = 32'h0000_0000;    // see [RULE7]
    if (!fifo_empty) begin       // see [RULE5]
      stat_img[uts_pkg::EP_MSB:uts_pkg::EP_LSB] =
        head.last_endpoint_number;                  // see [RULE1]
      stat_img[uts_pkg::DIR_BIT]  = head.tx_dir;   // see [RULE2]
      stat_img[uts_pkg::BANK_BIT] =
        head.pingpong_bank_indicator;               // see [RULE3]
    end
  end

  // Read mux, captured during the setup phase
  always_comb begin
    rdata_d = rdata_q;
    if (i_psel && !i_penable && !i_pwrite) begin
      unique case (i_paddr)
        uts_pkg::STAT_OFS:  rdata_d = stat_img;
        uts_pkg::ADDR_OFS:  rdata_d = {24'h00_0000, addr_q};
        uts_pkg::IFLAG_OFS: rdata_d = {24'h00_0000, flags};
        uts_pkg::IMASK_OFS: rdata_d = {24'h00_0000, mask_q};
        uts_pkg::LEVEL_OFS: rdata_d = 32'(fifo_cnt);
        default:            rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_prdata = rd_en ? rdata_q : 32'h0000_0000;

endmodule // uts_status_top
`default_nettype wire

// file: dv/uts_checker.sv
// Port-level assertions for the transaction status top level
`timescale 1ns/100ps
`default_nettype none
module uts_checker (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [31:0] o_prdata,
  input wire logic        i_trn_done,
  input wire logic        o_low_speed_token_select,
  input wire logic [6:0]  o_function_address_field,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Access phase decode
  logic acc, map, rda, wra;
  assign acc = i_psel & i_penable;
  assign map = i_paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  assign rda = acc & !i_pwrite & (i_paddr == uts_pkg::ADDR_OFS);
  assign wra = acc & i_pwrite & (i_paddr == uts_pkg::ADDR_OFS);
  property p_rdy; acc |-> o_pready; endproperty
  property p_err; acc & !map |-> o_pslverr && o_prdata == 32'h0; endproperty
  property p_stz; acc & !i_pwrite & (i_paddr == uts_pkg::STAT_OFS) |->
    o_prdata[31:8] == 24'h0 && o_prdata[1:0] == 2'h0; endproperty
  property p_adw; wra |=> o_function_address_field == $past(i_pwdata[6:0]);
  endproperty
  property p_lsw; wra |=> o_low_speed_token_select == $past(i_pwdata[7]);
  endproperty
  property p_adr; rda |-> o_prdata ==
    {24'h0, o_low_speed_token_select, o_function_address_field}; endproperty
  property p_idl; !(acc & !i_pwrite) |-> o_prdata == 32'h0; endproperty
  property p_hld; !wra |=> $stable(o_function_address_field); endproperty
  property p_msk; acc & i_pwrite & (i_paddr == uts_pkg::IMASK_OFS) &
    (i_pwdata[7:0] == 8'h00) |=> !o_irq; endproperty
  a_rdy: assert property (p_rdy)
    else $error("pready low in access");
  a_err: assert property (p_err)
    else $error("unmapped access not refused");
  a_stz: assert property (p_stz)
    else $error("status spare bits set");
  a_adw: assert property (p_adw)
    else $error("address field not written");
  a_lsw: assert property (p_lsw)
    else $error("speed bit not written");
  a_adr: assert property (p_adr)
    else $error("address readback wrong");
  a_idl: assert property (p_idl)
    else $error("read data outside read");
  a_hld: assert property (p_hld)
    else $error("address field moved");
  a_msk: assert property (p_msk)
    else $error("interrupt high with mask clear");
  c_push: cover property (i_trn_done);
  c_irq: cover property ($rose(o_irq));
  c_err: cover property (o_pslverr);
endmodule // uts_checker
bind uts_status_top uts_checker uts_checker_i (.i_clk, .i_rst_n, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr,
  .o_prdata, .i_trn_done, .o_low_speed_token_select,
  .o_function_address_field, .o_irq);
`default_nettype wire

// file: dv/uts_usb_eng.sv
// Behavioural USB engine that reports completed transactions
`timescale 1ns/100ps
`default_nettype none
module uts_usb_eng (
  input  wire logic              i_clk,
  output var  uts_pkg::uts_rec_t o_rec,
  output logic                   o_done
);
  initial begin
    o_done = 1'b0;
    o_rec  = '0;
  end
  // Completion pulse, held high across a burst; record scrambled after
  task automatic send(input logic [5:0] r, input logic last);
    o_done <= 1'b1;
    o_rec  <= r;
    @(posedge i_clk);
    if (last) begin
      o_done <= 1'b0;
      o_rec  <= ~r;
    end
  endtask
endmodule // uts_usb_eng
`default_nettype wire

// file: dv/uts_status_top_tb.sv
// Self-checking bench for the transaction status FIFO
`timescale 1ns/100ps
`default_nettype none
module uts_status_top_tb;
  logic i_clk, i_rst_n, psel, pen, pwr, rdy, err, serr, done, low, irq;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, rdata, r;
  logic [6:0]        fadr;
  uts_pkg::uts_rec_t rec;
  int                error_cnt, checks;
  // Rows: record pushed beside the status word it must give
  logic [5:0]  row_rec [4] = '{6'h3f, 6'h00, 6'h2a, 6'h15};
  logic [31:0] row_st  [4] = '{32'hfc, 32'h00, 32'ha8, 32'h54};
  uts_status_top uts_status_top_i (.i_clk, .i_rst_n, .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(rdy), .o_pslverr(err), .o_prdata(rdata), .i_trn_done(done),
    .i_trn_rec(rec), .o_low_speed_token_select(low),
    .o_function_address_field(fadr), .o_irq(irq));
  uts_usb_eng uts_usb_eng_i (.i_clk, .o_rec(rec), .o_done(done));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // APB transfer: setup, access until pready, release, one idle edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk) pen <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (rdy !== 1'b1 && n < 16);
    if (n == 16) error_cnt++;
    r = rdata;
    serr = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  task automatic give_verdict;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #(50 * 4000);
    error_cnt++;
    give_verdict;
  end
  initial begin
    {i_rst_n, psel, pen, pwr, paddr, pwdata} = '0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(uts_pkg::ADDR_OFS, 32'h0);
    rd(uts_pkg::IFLAG_OFS, 32'h0);
    rd(uts_pkg::IMASK_OFS, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      uts_usb_eng_i.send(row_rec[i], 1'b1);
      rd(uts_pkg::IFLAG_OFS, 32'h8);
      rd(uts_pkg::STAT_OFS, row_st[i]);
      apb(1'b1, uts_pkg::IFLAG_OFS, 32'h8);
      rd(uts_pkg::IFLAG_OFS, 32'h0);
    end
    $display("test rows done");
    apb(1'b1, uts_pkg::IMASK_OFS, 32'h9);
    for (int i = 0; i < 5; i++) uts_usb_eng_i.send(row_rec[i % 4], i == 4);
    rd(uts_pkg::IFLAG_OFS, 32'h9);
    chk({31'h0, irq}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      rd(uts_pkg::STAT_OFS, row_st[i]);
      apb(1'b1, uts_pkg::IFLAG_OFS, 32'h8);
    end
    rd(uts_pkg::IFLAG_OFS, 32'h1);
    apb(1'b1, uts_pkg::IFLAG_OFS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    $display("test fifo done");
    apb(1'b1, uts_pkg::ADDR_OFS, 32'hffffff80);
    rd(uts_pkg::ADDR_OFS, 32'h80);
    chk({24'h0, low, fadr}, 32'h80);
    apb(1'b1, uts_pkg::ADDR_OFS, 32'h7f);
    chk({24'h0, low, fadr}, 32'h7f);
    apb(1'b1, uts_pkg::STAT_OFS, 32'hffffffff);
    rd(uts_pkg::STAT_OFS, 32'h0);
    rd(8'h14, 32'h0);
    chk({31'h0, serr}, 32'h1);
    rd(uts_pkg::LEVEL_OFS, 32'h0);
    $display("test regs done");
    give_verdict;
  end
endmodule // uts_status_top_tb
`default_nettype wire
